// *** lps_pkg.sv ***
/*
 * Constants for the load protection and status block: command codes,
 * bit positions of the status registers, reset values and limits.
 * Assumes a command decoder outside that turns host text into codes.
 */
package lps_pkg;

   localparam int NMOD = 15;                  // Primary unit plus fourteen followers
   localparam int VW   = 16;                  // Width of voltage words
   localparam int DW   = 32;                  // Width of command and answer data

   // Command codes from the host command decoder
   typedef enum logic [4:0] {
      CMD_NONE,
      CMD_HV_LIMIT_SET,  CMD_HV_LIMIT_GET,  CMD_HV_ERR_CLR,  CMD_HV_ERR_GET,
      CMD_LV_LIMIT_SET,  CMD_LV_LIMIT_GET,  CMD_LV_ERR_CLR,  CMD_LV_ERR_GET,
      CMD_PULSE_SET,     CMD_PULSE_GET,     CMD_PULSE_TRIG,
      CMD_CHAN_EVT_GET,  CMD_CHAN_COND_GET, CMD_CHAN_CLEAR,
      CMD_CHAN_MASK_SET, CMD_CHAN_MASK_GET,
      CMD_SUM_EVT_GET,   CMD_SUM_MASK_SET,  CMD_SUM_MASK_GET,
      CMD_OPER_EVT_GET
   } lps_cmd_e;

   // Pulse configuration field selectors
   localparam logic [1:0] PF_PEAK   = 2'h0;
   localparam logic [1:0] PF_DUR    = 2'h1;
   localparam logic [1:0] PF_PERIOD = 2'h2;
   localparam logic [1:0] PF_COUNT  = 2'h3;

   localparam logic [15:0] PULSE_CNT_DEF = 16'h0001;
   localparam logic [15:0] PULSE_CNT_MAX = 16'hFDE8;   // 65,000

   // Channel condition, mask and event bit positions
   localparam int CH_VOLTAGE_FAULT = 0;
   localparam int CH_EXCESS_CURR   = 1;
   localparam int CH_EXCESS_POWER  = 3;
   localparam int CH_HEAT_LIMIT    = 4;
   localparam int CH_EXCESS_VOLT   = 12;
   localparam int CH_SAFE_SHUTDOWN = 13;
   localparam logic [15:0] CH_USED = 16'h301B;

   // Module summary bits: bit 0 primary unit, bits 1..14 followers
   localparam int             SUM_PRIMARY_BIT = 0;
   localparam logic [15:0] SUM_USED           = 16'h7FFF;

   // Operation event bit positions
   localparam int OP_POWER_UP     = 7;
   localparam int OP_SYNTAX_ERR   = 5;
   localparam int OP_EXEC_ERR     = 4;
   localparam int OP_DEVICE_ERR   = 3;
   localparam int OP_QUERY_ERR    = 2;
   localparam logic [7:0] OP_USED  = 8'hBC;
   localparam logic [7:0] OP_RESET = 8'h80;

endpackage

// *** lps_status.sv ***
/*
 * Protection limits, sticky voltage errors, voltage pulse settings and
 * the channel, module summary and operation status registers.
 * Assumes a decoder outside that delivers one decoded host command per
 * cycle on cmd_valid, a non-volatile store that presents the saved limits,
 * and measurements and live module conditions synchronous to mclk.
 */
// Functional notes
// - High voltage limit saved, reloaded at power-up
// - Clear command with zero resets high voltage error
// - High voltage error query answers one or zero
// - Low voltage limit saved, reloaded at power-up
// - Input below low limit raises low voltage error
// - Clear command with zero resets low voltage error
// - Low voltage error query answers one or zero
// - Pulse count defaults to one, at most 65000
// - Pulse settings stored, started only by trigger
// - Pulse query returns peak, duration, count, period
// - Channel event bits latch until explicit clear
// - Shared channel bit layout, unused bits zero
// - Condition register shows live module state
// - Channel clear zeroes mask bits, events reload live conditions
// - Only masked-in events reach summary bits
// - Channel mask written and read back unchanged; bits outside CH_USED are dropped on write and read back zero
// - Each module owns separate channel registers
// - Summary bit 0 primary, 1..14 followers
// - Summary mask gates summary event, read back
// - Operation events latch, cleared whole on read
// - Operation event bits 7,5,4,3,2, rest unused
// - Exceeded protection limit disengages load input
`timescale 1ns/100ps
`default_nettype none

module lps_status
   import lps_pkg::*;
(
   input  wire  logic                   mclk,
   input  wire  logic                   rst_b,
   // Decoded host commands
   input  wire  logic                   cmd_valid,
   input  wire  lps_cmd_e               cmd_code,
   input  wire  logic [3:0]             cmd_mod,
   input  wire  logic [1:0]             cmd_field,
   input  wire  logic [DW-1:0]          cmd_data,
   output logic                         rsp_valid,
   output logic [DW-1:0]                rsp_data,
   output logic                         rsp_present,
   // Non-volatile limit store
   input  wire  logic [VW-1:0]          nv_high_limit,
   input  wire  logic [VW-1:0]          nv_low_limit,
   output logic                         nv_store,
   output logic                         nv_store_low,
   output logic [VW-1:0]                nv_store_data,
   // Measurements and live module conditions
   input  wire  logic [VW-1:0]          v_meas,
   input  wire  logic [NMOD-1:0][15:0]  load_module_cond,
   input  wire  logic [7:0]             oper_event_in,
   // Power stage
   output logic                         load_disengage,
   output logic                         pulse_trigger_cmd,
   output logic [VW-1:0]                pulse_peak,
   output logic [DW-1:0]                pulse_dur,
   output logic [DW-1:0]                pulse_period,
   output logic                         pulse_period_set,
   output logic [15:0]                  pulse_count
);

   typedef struct packed {
      logic                    boot;
      logic [VW-1:0]           high_limit;
      logic [VW-1:0]           low_limit;
      logic                    high_err;
      logic                    low_err;
      logic [VW-1:0]           peak;
      logic [DW-1:0]           dur;
      logic [DW-1:0]           period;
      logic                    period_set;
      logic [15:0]             count;
      logic                    trig;
      logic [NMOD-1:0][15:0]   chan_evt;
      logic [NMOD-1:0][15:0]   chan_mask;
      logic [15:0]             sum_mask;
      logic [15:0]             sum_evt;
      logic [7:0]              oper;
      logic                    disengage;
      logic                    rsp_valid;
      logic [DW-1:0]           rsp_data;
      logic                    rsp_present;
      logic                    nv_store;
      logic                    nv_low;
      logic [VW-1:0]           nv_data;
   } lps_s;

   lps_s                  st;
   lps_s                  next_st;
   logic [NMOD-1:0][15:0] live_cond;
   logic [15:0]           sum_bits;
   logic                  high_trip;
   logic                  low_trip;
   logic                  mod_ok;

   // ***********************************************************
   // Live conditions and module summary
   // ***********************************************************
   // Limits are not valid until the boot cycle has loaded them
   assign high_trip = !st.boot && (v_meas > st.high_limit);
   assign low_trip  = !st.boot && (v_meas < st.low_limit);
   assign mod_ok    = (32'(cmd_mod) < NMOD);

   genvar m;
   generate
      for (m = 0; m < NMOD; m++) begin : g_mod
         // High voltage trip shows on the primary unit only
         if (m == SUM_PRIMARY_BIT) begin : g_prim
            assign live_cond[m] = (load_module_cond[m] & CH_USED)
                                  | ({16{high_trip}} & (16'h0001 << CH_EXCESS_VOLT));
         end else begin : g_foll
            assign live_cond[m] = load_module_cond[m] & CH_USED;
         end
         assign sum_bits[m] = |(st.chan_evt[m] & st.chan_mask[m]);
      end
   endgenerate
   assign sum_bits[15] = 1'b0;

   // ***********************************************************
   // Next state
   // ***********************************************************
   always_comb begin
      next_st             = st;
      next_st.boot        = 1'b0;
      next_st.trig        = 1'b0;
      next_st.rsp_valid   = 1'b0;
      next_st.rsp_present = 1'b0;
      next_st.nv_store    = 1'b0;

      // Limits come back from the non-volatile store after power-up
      if (st.boot) begin
         next_st.high_limit = nv_high_limit;
         next_st.low_limit  = nv_low_limit;
      end

      // Channel and operation events latch; a clear in the same cycle loses to a new event
      for (int i = 0; i < NMOD; i++) begin
         next_st.chan_evt[i] = st.chan_evt[i] | live_cond[i];
      end
      next_st.sum_evt = sum_bits & st.sum_mask & SUM_USED;
      next_st.oper    = st.oper | (oper_event_in & OP_USED);

      if (cmd_valid) begin
         next_st.rsp_valid = 1'b1;
         next_st.rsp_data  = '0;
         case (cmd_code)
            CMD_HV_LIMIT_SET: begin
               next_st.high_limit = cmd_data[VW-1:0];
               next_st.nv_store   = 1'b1;
               next_st.nv_low     = 1'b0;
               next_st.nv_data    = cmd_data[VW-1:0];
            end
            CMD_HV_LIMIT_GET: next_st.rsp_data = DW'(st.high_limit);
            CMD_HV_ERR_CLR: begin
               if (cmd_data == '0) next_st.high_err = 1'b0;
               else next_st.oper[OP_EXEC_ERR] = 1'b1;
            end
            CMD_HV_ERR_GET: next_st.rsp_data = DW'(st.high_err);
            CMD_LV_LIMIT_SET: begin
               next_st.low_limit = cmd_data[VW-1:0];
               next_st.nv_store  = 1'b1;
               next_st.nv_low    = 1'b1;
               next_st.nv_data   = cmd_data[VW-1:0];
            end
            CMD_LV_LIMIT_GET: next_st.rsp_data = DW'(st.low_limit);
            CMD_LV_ERR_CLR: begin
               if (cmd_data == '0) next_st.low_err = 1'b0;
               else next_st.oper[OP_EXEC_ERR] = 1'b1;
            end
            CMD_LV_ERR_GET: next_st.rsp_data = DW'(st.low_err);
            CMD_PULSE_SET: begin
               case (cmd_field)
                  PF_PEAK: begin
                     // A new set of settings starts with the default count and no period; duration is kept
                     next_st.peak       = cmd_data[VW-1:0];
                     next_st.count      = PULSE_CNT_DEF;
                     next_st.period_set = 1'b0;
                  end
                  PF_DUR:    next_st.dur = cmd_data;
                  PF_PERIOD: begin
                     next_st.period     = cmd_data;
                     next_st.period_set = 1'b1;
                  end
                  PF_COUNT: begin
                     if (cmd_data[31:16] == '0 && cmd_data[15:0] <= PULSE_CNT_MAX && cmd_data[15:0] != '0)
                        next_st.count = cmd_data[15:0];
                     else
                        next_st.oper[OP_EXEC_ERR] = 1'b1;
                  end
                  default: next_st.oper[OP_EXEC_ERR] = 1'b1;
               endcase
            end
            CMD_PULSE_GET: begin
               next_st.rsp_present = 1'b1;
               case (cmd_field)
                  PF_PEAK:   next_st.rsp_data = DW'(st.peak);
                  PF_DUR:    next_st.rsp_data = st.dur;
                  PF_COUNT:  next_st.rsp_data = DW'(st.count);
                  PF_PERIOD: begin
                     next_st.rsp_data    = st.period_set ? st.period : '0;
                     next_st.rsp_present = st.period_set;
                  end
                  default:   next_st.rsp_data = '0;
               endcase
            end
            CMD_PULSE_TRIG: next_st.trig = 1'b1;
            CMD_CHAN_EVT_GET: begin
               if (mod_ok) next_st.rsp_data = DW'(st.chan_evt[cmd_mod]);
               else next_st.oper[OP_QUERY_ERR] = 1'b1;
            end
            CMD_CHAN_COND_GET: begin
               if (mod_ok) next_st.rsp_data = DW'(live_cond[cmd_mod]);
               else next_st.oper[OP_QUERY_ERR] = 1'b1;
            end
            CMD_CHAN_CLEAR: begin
               if (mod_ok && cmd_data == '0) begin
                  next_st.chan_mask[cmd_mod] = '0;
                  next_st.chan_evt[cmd_mod]  = live_cond[cmd_mod];
               end else begin
                  next_st.oper[OP_EXEC_ERR] = 1'b1;
               end
            end
            CMD_CHAN_MASK_SET: begin
               if (mod_ok) next_st.chan_mask[cmd_mod] = cmd_data[15:0] & CH_USED;
               else next_st.oper[OP_EXEC_ERR] = 1'b1;
            end
            CMD_CHAN_MASK_GET: begin
               if (mod_ok) next_st.rsp_data = DW'(st.chan_mask[cmd_mod]);
               else next_st.oper[OP_QUERY_ERR] = 1'b1;
            end
            CMD_SUM_EVT_GET:  next_st.rsp_data = DW'(st.sum_evt);
            CMD_SUM_MASK_SET: next_st.sum_mask = cmd_data[15:0] & SUM_USED;
            CMD_SUM_MASK_GET: next_st.rsp_data = DW'(st.sum_mask);
            CMD_OPER_EVT_GET: begin
               next_st.rsp_data = DW'(st.oper);
               next_st.oper     = oper_event_in & OP_USED;
            end
            default: next_st.oper[OP_SYNTAX_ERR] = 1'b1;
         endcase
      end

      // Trips are applied last so that a trip beats a clear in the same cycle
      if (high_trip && !st.boot) next_st.high_err = 1'b1;
      if (low_trip && !st.boot)  next_st.low_err  = 1'b1;
      next_st.disengage = next_st.high_err | next_st.low_err
                          | live_cond[SUM_PRIMARY_BIT][CH_SAFE_SHUTDOWN];
   end

   // ***********************************************************
   // State register
   // ***********************************************************
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         st       <= '0;
         st.boot  <= 1'b1;
         st.count <= PULSE_CNT_DEF;
         st.oper  <= OP_RESET;
      end else begin
         st <= next_st;
      end
   end

   assign rsp_valid         = st.rsp_valid;
   assign rsp_data          = st.rsp_data;
   assign rsp_present       = st.rsp_present;
   assign nv_store          = st.nv_store;
   assign nv_store_low      = st.nv_low;
   assign nv_store_data     = st.nv_data;
   assign load_disengage    = st.disengage;
   assign pulse_trigger_cmd = st.trig;
   assign pulse_peak        = st.peak;
   assign pulse_dur         = st.dur;
   assign pulse_period      = st.period;
   assign pulse_period_set  = st.period_set;
   assign pulse_count       = st.count;

   // ***********************************************************
   // Assertions
   // ***********************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);

   a_high_err_sets: assert property (!st.boot && high_trip |=> st.high_err)
      else $error("high voltage error not set by trip");
   a_low_err_sets: assert property (!st.boot && low_trip |=> st.low_err)
      else $error("low voltage error not set by trip");
   a_high_err_clear: assert property (cmd_valid && cmd_code == CMD_HV_ERR_CLR && cmd_data == '0
                                      && !high_trip |=> !st.high_err)
      else $error("high voltage error not cleared");
   a_low_err_query: assert property (cmd_valid && cmd_code == CMD_LV_ERR_GET
                                     |=> rsp_valid && rsp_data == DW'($past(st.low_err)))
      else $error("low voltage error query wrong");
   a_boot_reload: assert property (st.boot |=> st.high_limit == $past(nv_high_limit)
                                   && st.low_limit == $past(nv_low_limit))
      else $error("limits not reloaded after reset");
   a_chan_evt_hold: assert property (!(cmd_valid && cmd_code == CMD_CHAN_CLEAR)
                                     |=> (st.chan_evt[0] & $past(st.chan_evt[0])) == $past(st.chan_evt[0]))
      else $error("channel event bit lost without clear");
   a_chan_unused: assert property (((st.chan_evt[0] | st.chan_mask[0]) & ~CH_USED) == '0)
      else $error("unused channel bit set");
   a_sum_gate: assert property (##1 st.sum_evt == ($past(sum_bits) & $past(st.sum_mask)))
      else $error("summary event not gated by mask");
   a_oper_read_clr: assert property (cmd_valid && cmd_code == CMD_OPER_EVT_GET && oper_event_in == '0
                                     |=> st.oper == '0 && rsp_data == DW'($past(st.oper)))
      else $error("operation event not cleared on read");
   a_trig_only_cmd: assert property (!(cmd_valid && cmd_code == CMD_PULSE_TRIG) |=> !pulse_trigger_cmd)
      else $error("pulse started without trigger");
   a_disengage: assert property (st.high_err || st.low_err |-> load_disengage)
      else $error("load not disengaged on protection error");
   a_count_max: assert property (pulse_count <= PULSE_CNT_MAX && pulse_count != '0)
      else $error("pulse count out of range");
   a_hv_store: assert property (cmd_valid && cmd_code == CMD_HV_LIMIT_SET
                                |=> nv_store && !nv_store_low && nv_store_data == $past(cmd_data[VW-1:0]))
      else $error("high voltage limit not stored");
   a_high_err_query: assert property (cmd_valid && cmd_code == CMD_HV_ERR_GET
                                      |=> rsp_valid && rsp_data == DW'($past(st.high_err)))
      else $error("high voltage error query wrong");
   a_low_err_clear: assert property (cmd_valid && cmd_code == CMD_LV_ERR_CLR && cmd_data == '0
                                     && !low_trip |=> !st.low_err)
      else $error("low voltage error not cleared");
   a_chan_clear: assert property (cmd_valid && cmd_code == CMD_CHAN_CLEAR && cmd_data == '0 && mod_ok
                                  |=> st.chan_mask[$past(cmd_mod)] == '0)
      else $error("channel mask not cleared");
   a_mask_readback: assert property (cmd_valid && cmd_code == CMD_CHAN_MASK_GET && mod_ok
                                     |=> rsp_data == DW'($past(st.chan_mask[cmd_mod])))
      else $error("channel mask read back wrong");
   a_sum_unused: assert property (st.sum_evt[15] == 1'b0 && st.sum_mask[15] == 1'b0)
      else $error("unused summary bit set");
   a_oper_unused: assert property ((st.oper & ~OP_USED) == '0)
      else $error("unused operation event bit set");

   c_high_trip:  cover property (high_trip ##[1:4] load_disengage);
   c_oper_read:  cover property (cmd_valid && cmd_code == CMD_OPER_EVT_GET && st.oper != '0);
   c_chan_clear: cover property (cmd_valid && cmd_code == CMD_CHAN_CLEAR ##1 st.chan_mask[0] == '0);
   c_pulse_trig: cover property (pulse_trigger_cmd && pulse_period_set);
   c_sum_event:  cover property (st.sum_evt != '0);

endmodule

`default_nettype wire

// *** lps_nv_model.sv ***
/*
 * Non-volatile limit store model that sits beside the status block.
 * Assumes the block presents one store pulse per limit change on mclk.
 */
`timescale 1ns/100ps
`default_nettype none

module lps_nv_model
   import lps_pkg::*;
#(
   parameter logic [VW-1:0] HIGH_INIT = 16'h0500,
   parameter logic [VW-1:0] LOW_INIT  = 16'h0100
)
(
   input  wire  logic            mclk,
   input  wire  logic            nv_store,
   input  wire  logic            nv_store_low,
   input  wire  logic [VW-1:0]   nv_store_data,
   output var   logic [VW-1:0]   nv_high_limit,
   output var   logic [VW-1:0]   nv_low_limit
);
   // ************************************************************
   // Saved limits survive every reset of the block
   // ************************************************************
   initial begin
      nv_high_limit = HIGH_INIT;
      nv_low_limit  = LOW_INIT;
   end

   always @(posedge mclk) begin
      if (nv_store && !nv_store_low) begin
         nv_high_limit <= nv_store_data;
      end
      if (nv_store && nv_store_low) begin
         nv_low_limit <= nv_store_data;
      end
   end
endmodule
`default_nettype wire

// *** testbench.sv ***
/*
 * Self-checking bench for lps_status: host command tasks and scenarios.
 * Assumes one command per cycle and the answer one cycle after taking.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end

module testbench;
   import lps_pkg::*;
   logic                  mclk, rst_b, cmd_valid, rsp_valid, rsp_present;
   lps_cmd_e              cmd_code;
   logic [3:0]            cmd_mod;
   logic [1:0]            cmd_field;
   logic [DW-1:0]         cmd_data, rsp_data, pulse_dur, pulse_period;
   logic                  nv_store, nv_store_low, load_disengage, pulse_trigger_cmd, pulse_period_set;
   logic [VW-1:0]         nv_high_limit, nv_low_limit, nv_store_data, v_meas, pulse_peak;
   logic [NMOD-1:0][15:0] load_module_cond;
   logic [7:0]            oper_event_in;
   logic [15:0]           pulse_count;
   logic                  got_v, got_p, got_t, got_s, got_l;
   logic [DW-1:0]         got_d;
   int                    miscompares = 0;
   int                    num_checks = 0;

   lps_status lps_status_i (.mclk(mclk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .cmd_mod(cmd_mod), .cmd_field(cmd_field), .cmd_data(cmd_data), .rsp_valid(rsp_valid),
      .rsp_data(rsp_data), .rsp_present(rsp_present), .nv_high_limit(nv_high_limit),
      .nv_low_limit(nv_low_limit), .nv_store(nv_store), .nv_store_low(nv_store_low),
      .nv_store_data(nv_store_data), .v_meas(v_meas), .load_module_cond(load_module_cond),
      .oper_event_in(oper_event_in), .load_disengage(load_disengage),
      .pulse_trigger_cmd(pulse_trigger_cmd), .pulse_peak(pulse_peak), .pulse_dur(pulse_dur),
      .pulse_period(pulse_period), .pulse_period_set(pulse_period_set), .pulse_count(pulse_count));

   lps_nv_model lps_nv_model_i (.mclk(mclk), .nv_store(nv_store), .nv_store_low(nv_store_low),
      .nv_store_data(nv_store_data), .nv_high_limit(nv_high_limit), .nv_low_limit(nv_low_limit));

   // ************************************************************
   // Clock, host tasks and closing
   // ************************************************************
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic do_reset();
      rst_b = 1'b0;
      idle(10);
      rst_b = 1'b1;
      idle(2);
   endtask

   task automatic cmd(input lps_cmd_e c, input logic [3:0] m, input logic [1:0] f, input logic [DW-1:0] d);
      @(negedge mclk);
      cmd_valid = 1'b1;
      cmd_code  = c;
      cmd_mod   = m;
      cmd_field = f;
      cmd_data  = d;
      @(negedge mclk);
      cmd_valid = 1'b0;
      cmd_code  = CMD_NONE;
      got_v = rsp_valid;
      got_d = rsp_data;
      got_p = rsp_present;
      got_t = pulse_trigger_cmd;
      got_s = nv_store;
      got_l = nv_store_low;
      `CHK("rsp_valid", 1'b1, got_v)
   endtask

   task automatic q(input lps_cmd_e c, input logic [3:0] m, input logic [1:0] f, input logic [DW-1:0] e);
      cmd(c, m, f, 32'h0);
      `CHK(c.name(), e, got_d)
   endtask

   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   initial begin
      idle(5000);
      miscompares++;
      wrap_up();
   end

   // ************************************************************
   // Scenarios
   // ************************************************************
   initial begin
      rst_b = 1'b0; cmd_valid = 1'b0; cmd_code = CMD_NONE; cmd_mod = 4'h0; cmd_field = 2'h0;
      cmd_data = 32'h0; v_meas = 16'h0300; load_module_cond = '0; oper_event_in = 8'h00;
      do_reset();
      q(CMD_CHAN_EVT_GET, 4'h0, 2'h0, 32'h0);
      q(CMD_OPER_EVT_GET, 4'h0, 2'h0, 32'h80);
      q(CMD_OPER_EVT_GET, 4'h0, 2'h0, 32'h00);
      q(CMD_HV_LIMIT_GET, 4'h0, 2'h0, 32'h0500);
      cmd(CMD_HV_LIMIT_SET, 4'h0, 2'h0, 32'h0600);
      `CHK("hv store", {3'b101, 16'h0600}, {got_s, got_l, got_d == 0, nv_store_data})
      cmd(CMD_LV_LIMIT_SET, 4'h0, 2'h0, 32'h0080);
      `CHK("lv store", 2'b11, {got_s, got_l})
      do_reset();
      q(CMD_HV_LIMIT_GET, 4'h0, 2'h0, 32'h0600);
      q(CMD_LV_LIMIT_GET, 4'h0, 2'h0, 32'h0080);
      q(CMD_OPER_EVT_GET, 4'h0, 2'h0, 32'h80);
      // Voltage above the high limit, then back inside the window
      v_meas = 16'h0700;
      idle(3);
      `CHK("disengage", 1'b1, load_disengage)
      q(CMD_HV_ERR_GET, 4'h0, 2'h0, 32'h1);
      q(CMD_CHAN_COND_GET, 4'h0, 2'h0, 32'h1000);
      v_meas = 16'h0300;
      idle(2);
      q(CMD_HV_ERR_GET, 4'h0, 2'h0, 32'h1);
      cmd(CMD_HV_ERR_CLR, 4'h0, 2'h0, 32'h1);
      q(CMD_HV_ERR_GET, 4'h0, 2'h0, 32'h1);
      q(CMD_OPER_EVT_GET, 4'h0, 2'h0, 32'h10);
      cmd(CMD_HV_ERR_CLR, 4'h0, 2'h0, 32'h0);
      q(CMD_HV_ERR_GET, 4'h0, 2'h0, 32'h0);
      q(CMD_CHAN_EVT_GET, 4'h0, 2'h0, 32'h1000);
      idle(2);
      `CHK("disengage", 1'b0, load_disengage)
      v_meas = 16'h0050;
      idle(3);
      v_meas = 16'h0300;
      q(CMD_LV_ERR_GET, 4'h0, 2'h0, 32'h1);
      cmd(CMD_LV_ERR_CLR, 4'h0, 2'h0, 32'h0);
      q(CMD_LV_ERR_GET, 4'h0, 2'h0, 32'h0);
      // Pulse train settings; duration and period gap kept legal by the host
      cmd(CMD_PULSE_SET, 4'h0, PF_PEAK, 32'h0123);
      q(CMD_PULSE_GET, 4'h0, PF_COUNT, 32'h1);
      q(CMD_PULSE_GET, 4'h0, PF_PERIOD, 32'h0);
      `CHK("period present", 1'b0, got_p)
      cmd(CMD_PULSE_SET, 4'h0, PF_DUR, 32'h14);
      cmd(CMD_PULSE_SET, 4'h0, PF_PERIOD, 32'h28);
      cmd(CMD_PULSE_SET, 4'h0, PF_COUNT, 32'hFDE8);
      `CHK("no start", 1'b0, got_t)
      cmd(CMD_PULSE_SET, 4'h0, PF_COUNT, 32'hFDE9);
      q(CMD_PULSE_GET, 4'h0, PF_COUNT, 32'hFDE8);
      q(CMD_PULSE_GET, 4'h0, PF_PEAK, 32'h0123);
      q(CMD_PULSE_GET, 4'h0, PF_DUR, 32'h14);
      q(CMD_PULSE_GET, 4'h0, PF_PERIOD, 32'h28);
      `CHK("period present", 1'b1, got_p)
      `CHK("pulse out", {16'h0123, 32'h14, 32'h28, 1'b1, 16'hFDE8}, {pulse_peak, pulse_dur, pulse_period, pulse_period_set, pulse_count})
      cmd(CMD_PULSE_TRIG, 4'h0, 2'h0, 32'h0);
      `CHK("trigger", 1'b1, got_t)
      // Channel registers of module 3, summary through bit 3
      load_module_cond[3] = 16'hFFFF;
      idle(3);
      q(CMD_CHAN_COND_GET, 4'h3, 2'h0, {16'h0, CH_USED});
      load_module_cond[3] = 16'h0000;
      idle(3);
      q(CMD_CHAN_COND_GET, 4'h3, 2'h0, 32'h0);
      q(CMD_CHAN_EVT_GET, 4'h3, 2'h0, 32'h301B);
      q(CMD_CHAN_EVT_GET, 4'h4, 2'h0, 32'h0);
      cmd(CMD_CHAN_MASK_SET, 4'h3, 2'h0, 32'h0002);
      q(CMD_CHAN_MASK_GET, 4'h3, 2'h0, 32'h0002);
      cmd(CMD_SUM_MASK_SET, 4'h0, 2'h0, 32'h0009);
      q(CMD_SUM_MASK_GET, 4'h0, 2'h0, 32'h0009);
      idle(3);
      q(CMD_SUM_EVT_GET, 4'h0, 2'h0, 32'h0008);
      cmd(CMD_CHAN_MASK_SET, 4'h3, 2'h0, 32'h0004);
      idle(3);
      q(CMD_SUM_EVT_GET, 4'h0, 2'h0, 32'h0);
      cmd(CMD_CHAN_MASK_SET, 4'h3, 2'h0, 32'h1000);
      cmd(CMD_SUM_MASK_SET, 4'h0, 2'h0, 32'h0001);
      idle(3);
      q(CMD_SUM_EVT_GET, 4'h0, 2'h0, 32'h0);
      cmd(CMD_CHAN_CLEAR, 4'h3, 2'h0, 32'h0);
      q(CMD_CHAN_MASK_GET, 4'h3, 2'h0, 32'h0);
      q(CMD_CHAN_EVT_GET, 4'h3, 2'h0, 32'h0);
      // Unknown command, refused module index and an external event pulse
      q(CMD_OPER_EVT_GET, 4'h0, 2'h0, 32'h10);
      cmd(CMD_NONE, 4'h0, 2'h0, 32'h0);
      q(CMD_CHAN_EVT_GET, 4'hF, 2'h0, 32'h0);
      @(negedge mclk);
      oper_event_in = 8'h08;
      @(negedge mclk);
      oper_event_in = 8'h00;
      q(CMD_OPER_EVT_GET, 4'h0, 2'h0, 32'h2C);
      q(CMD_OPER_EVT_GET, 4'h0, 2'h0, 32'h00);
      wrap_up();
   end
endmodule
`default_nettype wire
